/* File: core/eoc_ctrl.sv */
// External oscillator control: control register, clock select, /8 peripheral
// tick, crystal valid flag and interrupt, on a classic Wishbone slave.
// Assumes one 125 MHz clock; oscillator and amplitude detector come from pins.
//
// Contract
// RULE1: The external oscillator divided by eight is offered to timers and counter array.
// RULE2: Software keeps the external frequency at or below the system clock when used so.
// RULE3: The divided clock is resynchronised to the system clock with half-cycle jitter.
// RULE4: Software latches pins high, makes them analog, enables, waits 1 ms, polls, switches.
// RULE5: Software never selects the crystal as system clock before it is stable.
// RULE6: Bit 7 is a read-only valid flag, set only when a crystal mode runs stable.
// RULE7: Bits 6 to 4 pick off, CMOS clock, CMOS /2, RC, capacitor, crystal, crystal /2.
// RULE8: Bit 3 reads zero and software writes zero to it.
// RULE9: Bits 2 to 0 hold the drive range, read-write, passed on in every mode.
// RULE10: Software sets the drive range to match the crystal in crystal mode.
// RULE11: Hardware sets the valid flag once the oscillator settles, unaided.
// RULE12: A select bit picks internal at 0 or external at 1, switchable on the fly.
// RULE13: After reset the control register reads zero, oscillator off, flag clear.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
`include "eoc_consts.svh"
module eoc_ctrl (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire eoc_pkg::eoc_wb_req_t wb_req_i,
   output logic                     wb_ack_o,
   output logic [31:0]              wb_dat_o,
   input  wire logic                ext_osc_i,
   input  wire logic                amp_ok_i,
   output logic                     osc_enable_o,
   output logic [2:0]               osc_mode_o,
   output logic [2:0]               drive_range_o,
   output logic                     sysclk_sel_ext_o,
   output logic                     ext_div8_tick_o,
   output logic                     irq_o
);
   import eoc_pkg::*;

   eoc_ctrl_t            ctrl_q;
   logic [2:0]           mode_q;
   logic [2:0]           range_q;
   logic                 ack_q;
   logic [31:0]          rdat_q;
   logic                 clock_select_register_q;
   logic [`EOC_EV_W-1:0] status_q;
   logic [`EOC_EV_W-1:0] mask_q;
   logic [`EOC_EV_W-1:0] ev_set;
   logic                 osc_s1_q, osc_s2_q, osc_s3_q;
   logic                 amp_s1_q, amp_s2_q;
   logic                 half_q;
   logic [2:0]           div_cnt_q;
   logic                 tick_q;
   logic                 valid_q;
   logic                 en_q;
   logic                 irq_q;
   logic                 access, wr, rd;
   logic [7:0]           idx;
   logic                 osc_rise, osc_edge, div2_mode, xtal_mode;

   // Mode decode used by the divider and the oscillator enable
   function automatic logic is_div2(input logic [2:0] m);
      return m == `EOC_MODE_CMOS_D2 || m == `EOC_MODE_XTAL_D2;
   endfunction
   function automatic logic is_on(input logic [2:0] m);
      return m[2:1] != 2'h0;
   endfunction

   // Bus decode; a request is served in the cycle before ack
   assign access    = wb_req_i.cyc && wb_req_i.stb && !ack_q;
   assign wr        = access && wb_req_i.we && wb_req_i.sel[0];
   assign rd        = access && !wb_req_i.we;
   assign idx       = (wb_req_i.adr[31:10] == 22'h0) ? wb_req_i.adr[9:2] : 8'hff;
   assign div2_mode = is_div2(ctrl_q.ext_osc_mode_field);
   assign xtal_mode = ctrl_q.ext_osc_mode_field[2:1] == 2'h3;

   // Acknowledge one cycle after the strobe, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access;
      end
   end

   // Read data; unmapped indices read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0;
      end else if (rd) begin
         unique case (idx)
            `EOC_IDX_CTRL:   rdat_q <= {24'h0, ctrl_q};
            `EOC_IDX_CLOCK_SELECT_REGISTER: rdat_q <= {31'h0, clock_select_register_q};
            `EOC_IDX_STATUS: rdat_q <= {{(32-`EOC_EV_W){1'b0}}, status_q};
            `EOC_IDX_MASK:   rdat_q <= {{(32-`EOC_EV_W){1'b0}}, mask_q};
            default:         rdat_q <= 32'h0;
         endcase
      end
   end

   // Control register writes; flag and reserved bit are not writable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // RULE13: reset to off
         mode_q  <= 3'h0;
         range_q <= 3'h0;
      end else if (wr && idx == `EOC_IDX_CTRL) begin
         // RULE7: mode field store
         mode_q  <= wb_req_i.dat[6:4];
         // RULE9: drive range store
         range_q <= wb_req_i.dat[2:0];
      end
   end
   // RULE8: reserved bit zero; one driver for the whole register view
   assign ctrl_q = '{crystal_valid_flag:  valid_q,
                     ext_osc_mode_field:  mode_q,
                     reserved:            1'b0,
                     ext_osc_drive_range: range_q};

   // System clock select and interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_select_register_q <= 1'b0;
         mask_q   <= '0;
      end else if (wr) begin
         // RULE12: source select write
         if (idx == `EOC_IDX_CLOCK_SELECT_REGISTER) clock_select_register_q <= wb_req_i.dat[0];
         if (idx == `EOC_IDX_MASK) mask_q <= wb_req_i.dat[`EOC_EV_W-1:0];
      end
   end

   // Pin synchronisers: two stages before any logic
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
         amp_s1_q <= 1'b0;
         amp_s2_q <= 1'b0;
      end else begin
         osc_s1_q <= ext_osc_i;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         amp_s1_q <= amp_ok_i;
         amp_s2_q <= amp_s1_q;
      end
   end

   // RULE3: edge taken in system clock domain
   assign osc_rise = osc_s2_q && !osc_s3_q && is_on(ctrl_q.ext_osc_mode_field);
   assign osc_edge = osc_rise && (!div2_mode || half_q);

   // RULE1: divide by eight into a one-cycle tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         half_q    <= 1'b0;
         div_cnt_q <= 3'h0;
         tick_q    <= 1'b0;
      end else begin
         if (osc_rise) half_q <= !half_q;
         if (osc_edge) div_cnt_q <= div_cnt_q + 3'h1;
         tick_q <= osc_edge && div_cnt_q == `EOC_DIV8_LAST;
      end
   end

   // RULE11: valid follows the settled detector in crystal modes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_q <= 1'b0;
      end else begin
         // RULE6: zero outside crystal modes
         valid_q <= xtal_mode && amp_s2_q;
      end
   end

   // Sticky events; a read clears, a new event wins
   assign ev_set[`EOC_EV_VALID_UP] = xtal_mode && amp_s2_q && !valid_q;
   assign ev_set[`EOC_EV_VALID_DN] = valid_q && !(xtal_mode && amp_s2_q);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= '0;
      end else if (rd && idx == `EOC_IDX_STATUS) begin
         status_q <= ev_set;
      end else begin
         status_q <= status_q | ev_set;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q  <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         en_q  <= is_on(ctrl_q.ext_osc_mode_field);
         irq_q <= |(status_q & mask_q);
      end
   end

   assign wb_ack_o         = ack_q;
   assign wb_dat_o         = rdat_q;
   assign osc_enable_o     = en_q;
   assign osc_mode_o       = ctrl_q.ext_osc_mode_field;
   assign drive_range_o    = ctrl_q.ext_osc_drive_range;
   assign sysclk_sel_ext_o = clock_select_register_q;
   assign ext_div8_tick_o  = tick_q;
   assign irq_o            = irq_q;

   // Checks
   property p_reset_zero;
      @(posedge clk_i) rst_i |=> ctrl_q == `EOC_CTRL_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset"); // RULE13

   property p_rsvd;
      @(posedge clk_i) disable iff (rst_i)
         rd && idx == `EOC_IDX_CTRL |=> !wb_dat_o[`EOC_CTRL_RSVD];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one"); // RULE8

   property p_valid_xtal;
      @(posedge clk_i) disable iff (rst_i) ctrl_q.crystal_valid_flag |-> $past(xtal_mode);
   endproperty
   a_valid_xtal: assert property (p_valid_xtal) else $error("valid outside crystal mode"); // RULE6

   property p_valid_set;
      @(posedge clk_i) disable iff (rst_i) xtal_mode && amp_s2_q |=> valid_q;
   endproperty
   a_valid_set: assert property (p_valid_set) else $error("valid not set when settled"); // RULE11

   property p_tick_gap;
      @(posedge clk_i) disable iff (rst_i) ext_div8_tick_o |=> !ext_div8_tick_o [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("divided ticks too close"); // RULE1

   property p_tick_time;
      @(posedge clk_i) disable iff (rst_i)
         osc_rise && !div2_mode && div_cnt_q == `EOC_DIV8_LAST |=> ext_div8_tick_o;
   endproperty
   a_tick_time: assert property (p_tick_time) else $error("tick late after eighth edge"); // RULE3

   property p_range_wr;
      @(posedge clk_i) disable iff (rst_i)
         wr && idx == `EOC_IDX_CTRL |=> drive_range_o == $past(wb_req_i.dat[2:0]);
   endproperty
   a_range_wr: assert property (p_range_wr) else $error("drive range not stored"); // RULE9

   property p_mode_off;
      @(posedge clk_i) disable iff (rst_i)
         wr && idx == `EOC_IDX_CTRL && wb_req_i.dat[6:5] == 2'h0 |-> ##3 !osc_enable_o;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("oscillator on in off mode"); // RULE7

   property p_clock_select_register;
      @(posedge clk_i) disable iff (rst_i)
         wr && idx == `EOC_IDX_CLOCK_SELECT_REGISTER |=> sysclk_sel_ext_o == $past(wb_req_i.dat[0]);
   endproperty
   a_clock_select_register: assert property (p_clock_select_register) else $error("clock select not stored"); // RULE12

   c_tick: cover property (@(posedge clk_i) disable iff (rst_i) ext_div8_tick_o);
   c_valid: cover property (@(posedge clk_i) disable iff (rst_i) $rose(valid_q));
   c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule

/* File: core/eoc_consts.svh */
// Offsets, field positions and reset values of the external oscillator control.
// Included by the package and the control module; definitions only.
`ifndef EOC_CONSTS_SVH
`define EOC_CONSTS_SVH
// Register indices; byte address is four times the index
`define EOC_IDX_CTRL      8'hb1
`define EOC_IDX_CLOCK_SELECT_REGISTER    8'hc0
`define EOC_IDX_STATUS    8'hc1
`define EOC_IDX_MASK      8'hc2
// Control register fields
`define EOC_CTRL_VALID    7
`define EOC_CTRL_RSVD     3
`define EOC_CTRL_RESET    8'h00
// Mode field encodings
`define EOC_MODE_CMOS     3'h2
`define EOC_MODE_CMOS_D2  3'h3
`define EOC_MODE_RC       3'h4
`define EOC_MODE_CAP      3'h5
`define EOC_MODE_XTAL     3'h6
`define EOC_MODE_XTAL_D2  3'h7
// Peripheral clock divide ratio, minus one
`define EOC_DIV8_LAST     3'h7
// Interrupt status bits: valid rose, valid fell
`define EOC_EV_VALID_UP   0
`define EOC_EV_VALID_DN   1
`define EOC_EV_W          2
`endif

/* File: core/eoc_pkg.sv */
// Types shared by the external oscillator control block.
// Assumes eoc_consts.svh is on the include path.
`include "eoc_consts.svh"
package eoc_pkg;
   // Layout of the control register
   typedef struct packed {
      logic       crystal_valid_flag;
      logic [2:0] ext_osc_mode_field;
      logic       reserved;
      logic [2:0] ext_osc_drive_range;
   } eoc_ctrl_t;

   // Classic Wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] adr;
      logic [31:0] dat;
   } eoc_wb_req_t;
endpackage

/* File: sim/eoc_osc_model.sv */
// Behavioural external oscillator and amplitude detector.
// Assumes the control block's enable and mode outputs, one system clock.
`timescale 1ns/10ps
module eoc_osc_model #(
   parameter int HALF   = 3,
   parameter int SETTLE = 40
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       osc_enable_i,
   input  wire logic [2:0] osc_mode_i,
   output logic            ext_osc_o,
   output logic            amp_ok_o
);
   int ph_q;
   int amp_q;
   // Pin toggles every HALF cycles while enabled and stands low when off
   // rate below sysclk
   always @(posedge clk_i) begin
      if (rst_i || !osc_enable_i) begin
         ph_q <= 0;
         ext_osc_o <= 1'b0;
      end else if (ph_q == HALF - 1) begin
         ph_q <= 0;
         ext_osc_o <= ~ext_osc_o;
      end else begin
         ph_q <= ph_q + 1;
      end
   end
   // Detector settles SETTLE cycles after a crystal mode starts
   always @(posedge clk_i) begin
      if (rst_i || osc_mode_i[2:1] != 2'b11) begin
         amp_q <= 0;
         amp_ok_o <= 1'b0;
      end else if (amp_q == SETTLE) begin
         amp_ok_o <= 1'b1;
      end else begin
         amp_q <= amp_q + 1;
      end
   end
endmodule

/* File: sim/eoc_ctrl_bench.sv */
// Self-checking bench for the oscillator control over classic Wishbone.
// Assumes eoc_consts.svh on the include path and the oscillator model.
`timescale 1ns/10ps
`include "eoc_consts.svh"
module eoc_ctrl_bench;
   import eoc_pkg::*;
   localparam int HALF = 3;
   localparam int WAIT_CYC = 60; // Scaled start-up wait
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   eoc_wb_req_t req = '0;
   logic        ack, ext_osc, amp_ok, osc_en, sel_ext, tick, irq;
   logic [31:0] dat;
   logic [31:0] rd;
   logic [2:0]  mode, range;
   logic [7:0]  regs [4] = '{`EOC_IDX_CTRL, `EOC_IDX_CLOCK_SELECT_REGISTER, `EOC_IDX_STATUS, `EOC_IDX_MASK};
   int          failures = 0;
   int          comparisons = 0;
   int          n;
   always #4 clk_i = ~clk_i;
   eoc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack),
      .wb_dat_o(dat), .ext_osc_i(ext_osc), .amp_ok_i(amp_ok), .osc_enable_o(osc_en),
      .osc_mode_o(mode), .drive_range_o(range), .sysclk_sel_ext_o(sel_ext),
      .ext_div8_tick_o(tick), .irq_o(irq));
   eoc_osc_model #(.HALF(HALF), .SETTLE(40)) osc_u (.clk_i(clk_i), .rst_i(rst_i),
      .osc_enable_i(osc_en), .osc_mode_i(mode), .ext_osc_o(ext_osc), .amp_ok_o(amp_ok));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Bounded-loop exhaustion counts as a mismatch and ends the run
   task automatic bound(input int cnt, input int lim);
      if (cnt >= lim) begin
         failures++;
         finish_test();
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      int k;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {22'h0, idx, 2'b00},
               dat: {24'h0, wd}};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      bound(k, 20);
      rd = dat;
      req <= '0;
   endtask
   task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 8'h00);
      check(name, rd, exp);
   endtask
   // Cycles between two consecutive peripheral ticks
   task automatic tick_gap(input int exp);
      int g;
      // Skip a tick launched by edges counted under the previous mode
      @(posedge clk_i);
      g = 0;
      while (tick !== 1'b1 && g < 400) begin
         @(posedge clk_i);
         g++;
      end
      bound(g, 400);
      g = 0;
      do begin
         @(posedge clk_i);
         g++;
      end while (tick !== 1'b1 && g < 400);
      bound(g, 400);
      check("tick_gap", g, exp);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("outs", {osc_en, mode, range, sel_ext, tick, irq}, 0);
      for (int i = 0; i < 4; i++) rdchk("reset_reg", regs[i], 0);
      // Unmapped place drops writes and reads zero
      wb(1'b1, 8'h10, 8'hff);
      rdchk("unmapped", 8'h10, 0);
      rdchk("unmapped_ctrl", `EOC_IDX_CTRL, 0);
      rdchk("unmapped_mask", `EOC_IDX_MASK, 0);
      for (int m = 0; m < 8; m++) begin
         wb(1'b1, `EOC_IDX_CTRL, {1'b0, m[2:0], 1'b0, 3'(7 - m)});
         rdchk("ctrl", `EOC_IDX_CTRL, {1'b0, m[2:0], 1'b0, 3'(7 - m)});
         check("pins", {osc_en, mode, range}, {m > 1, m[2:0], 3'(7 - m)});
      end
      wb(1'b1, `EOC_IDX_CTRL, 8'h20);
      tick_gap(16 * HALF);
      wb(1'b1, `EOC_IDX_CTRL, 8'h30);
      tick_gap(32 * HALF);
      wb(1'b1, `EOC_IDX_CTRL, 8'h00);
      repeat (10) @(posedge clk_i);
      n = 0;
      repeat (200) begin
         @(posedge clk_i);
         if (tick === 1'b1) n++;
      end
      check("ticks_off", n, 0);
      // Crystal start: enable, wait, poll, then switch
      wb(1'b1, `EOC_IDX_CTRL, 8'h67);
      repeat (WAIT_CYC) @(posedge clk_i);
      n = 0;
      do begin
         wb(1'b0, `EOC_IDX_CTRL, 8'h00);
         n++;
      end while (rd[7] !== 1'b1 && n < 10);
      bound(n, 10);
      check("ctrl_valid", rd, 32'he7);
      check("irq_masked", irq, 0);
      wb(1'b1, `EOC_IDX_MASK, 8'h03);
      repeat (2) @(posedge clk_i);
      check("irq_on", irq, 1);
      rdchk("status_up", `EOC_IDX_STATUS, 1);
      repeat (2) @(posedge clk_i);
      check("irq_off", irq, 0);
      rdchk("status_clr", `EOC_IDX_STATUS, 0);
      wb(1'b1, `EOC_IDX_CLOCK_SELECT_REGISTER, 8'h01);
      rdchk("clock_select_register", `EOC_IDX_CLOCK_SELECT_REGISTER, 1);
      check("sel_ext", sel_ext, 1);
      wb(1'b1, `EOC_IDX_CTRL, 8'h47);
      repeat (6) @(posedge clk_i);
      rdchk("ctrl_rc", `EOC_IDX_CTRL, 32'h47);
      rdchk("status_dn", `EOC_IDX_STATUS, 2);
      finish_test();
   end
endmodule
